// ### adc_seq_defines.svh
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH

// Register indices on the plain register port
`define REG_CTRL 3'h0
`define REG_SRC 3'h1
`define REG_REF 3'h2
`define REG_RES_HI 3'h3
`define REG_RES_LO 3'h4
`define REG_STAT 3'h5

// Control/start/status register fields
`define CTRL_START 7
`define CTRL_BUSY 6
`define CTRL_PWR 5
`define CTRL_ALIGN 4
`define CTRL_CH_HI 1
`define CTRL_CH_LO 0
`define CTRL_WMASK 8'hb3

// Source/clock register fields
`define SRC_INT_HI 7
`define SRC_INT_LO 5
`define SRC_DIV_HI 2
`define SRC_DIV_LO 0
`define SRC_WMASK 8'he7

// Reference/amp register fields
`define REF_OPA 7
`define REF_BGB 6
`define REF_SEL_HI 3
`define REF_SEL_LO 0
`define REF_WMASK 8'hcf

// Status register fields
`define STAT_IRQ 0

`define RESET_BYTE 8'h00

// Conversion timing in converter clock periods
`define SAMPLE_PERIODS 5'h04
`define CONVERT_PERIODS 5'h0c
`define TOTAL_PERIODS 5'h10

// Decoded reference codes
`define REF_AVDD 4'h0
`define REF_EXT_X1 4'h1
`define REF_EXT_X4 4'h4
`define REF_BG_X2 4'ha
`define REF_BG_X4 4'hc

`define INT_NONE 3'h0
`define INT_SUPPLY_MIN 3'h1
`define INT_SUPPLY_MAX 3'h3
`define INT_OPA_MIN 3'h5

`endif

// ### adc_seq_pkg.sv
package adc_seq_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_HOLD = 3'b010,
    ST_RUN = 3'b100
  } seq_state_t;

  typedef enum logic [1:0] {
    IN_EXTERNAL = 2'h0,
    IN_SUPPLY = 2'h1,
    IN_OPAMP = 2'h2
  } input_kind_t;

endpackage

// ### conv_tick_if.sv
interface conv_tick_if;
  logic [2:0] div_sel;
  logic tick;

  modport source (input div_sel, output tick);
  modport sink (output div_sel, input tick);
endinterface

// ### conv_prescaler.sv
`include "adc_seq_defines.svh"

module conv_prescaler
  import adc_seq_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Divider select and tick out
  conv_tick_if.source tk
);

  logic [6:0] count_r;
  logic [6:0] limit;

  // Free-running count, wraps at 2**sel - 1
  assign limit = 7'((8'h01 << tk.div_sel) - 8'h01);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      count_r <= 7'h00;
    end else if (count_r >= limit) begin
      count_r <= 7'h00;
    end else begin
      count_r <= count_r + 7'h01;
    end
  end

  assign tk.tick = (count_r >= limit);

endmodule // conv_prescaler

// ### result_store.sv
`include "adc_seq_defines.svh"

module result_store
  import adc_seq_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Capture side
  input wire logic capture,
  input wire logic [11:0] data_in,
  // Read side
  input wire logic align_sel,
  output logic [7:0] high_byte,
  output logic [7:0] low_byte
);

  logic [11:0] held_r;

  // Kept across power-down
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      held_r <= 12'h000;
    end else if (capture) begin
      held_r <= data_in;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      high_byte <= `RESET_BYTE;
      low_byte <= `RESET_BYTE;
    end else if (align_sel) begin
      high_byte <= {4'h0, held_r[11:8]};
      low_byte <= held_r[7:0];
    end else begin
      high_byte <= held_r[11:4];
      low_byte <= {held_r[3:0], 4'h0};
    end
  end

endmodule // result_store

// ### adc_control_sequencer.sv
// Added by the designer: the register offsets and strobed register access.
`include "adc_seq_defines.svh"

module adc_control_sequencer
  import adc_seq_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // Analog core controls
  output logic conv_power_enable,
  output logic core_reset,
  output logic sample_phase,
  output logic convert_phase,
  output logic [1:0] external_channel_select,
  output logic [1:0] input_kind,
  output logic [1:0] input_scale_log2,
  output logic [1:0] ref_kind,
  output logic [2:0] ref_multiple,
  output logic opamp_enable,
  output logic bandgap_buffer_enable,
  output logic opamp_input_bandgap,
  // Result from core
  input wire logic [11:0] core_result,
  // Interrupt request event to controller
  output logic conv_done_irq
);

  // Control registers
  logic start_r;
  logic power_r;
  logic align_r;
  logic [1:0] chan_r;
  logic [2:0] int_sel_r;
  logic [2:0] div_sel_r;
  logic opa_r;
  logic bgb_r;
  logic [3:0] ref_sel_r;
  logic busy_r;
  logic irq_flag_r;
  logic done_r;
  seq_state_t state_r;
  logic [4:0] period_r;
  logic [7:0] res_hi;
  logic [7:0] res_lo;
  logic finish;
  logic wr_ctrl;
  logic start_wr;
  logic start_nxt;
  logic [1:0] input_kind_nxt;
  logic [1:0] input_scale_nxt;
  logic [1:0] ref_kind_nxt;
  logic [2:0] ref_multiple_nxt;

  conv_tick_if tk ();

  assign tk.div_sel = div_sel_r;

  conv_prescaler u_prescaler (
    .clock(clock),
    .sys_rst(sys_rst),
    .tk(tk)
  );

  function automatic logic [3:0] ref_effective(input logic [3:0] code);
    if ((code >= `REF_EXT_X1 && code <= `REF_EXT_X4) ||
        (code >= `REF_BG_X2 && code <= `REF_BG_X4)) begin
      return code;
    end
    return `REF_AVDD;
  endfunction

  assign wr_ctrl = reg_write && (reg_addr == `REG_CTRL);
  assign start_wr = reg_wdata[`CTRL_START];
  assign start_nxt = wr_ctrl ? start_wr : start_r;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      start_r <= 1'b0;
      power_r <= 1'b0;
      align_r <= 1'b0;
      chan_r <= 2'h0;
    end else if (wr_ctrl) begin
      start_r <= start_wr;
      power_r <= reg_wdata[`CTRL_PWR];
      align_r <= reg_wdata[`CTRL_ALIGN];
      chan_r <= reg_wdata[`CTRL_CH_HI:`CTRL_CH_LO];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      int_sel_r <= 3'h0;
      div_sel_r <= 3'h0;
    end else if (reg_write && reg_addr == `REG_SRC) begin
      int_sel_r <= reg_wdata[`SRC_INT_HI:`SRC_INT_LO];
      div_sel_r <= reg_wdata[`SRC_DIV_HI:`SRC_DIV_LO];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      opa_r <= 1'b0;
      bgb_r <= 1'b0;
      ref_sel_r <= 4'h0;
    end else if (reg_write && reg_addr == `REG_REF) begin
      opa_r <= reg_wdata[`REF_OPA];
      bgb_r <= reg_wdata[`REF_BGB];
      ref_sel_r <= reg_wdata[`REF_SEL_HI:`REF_SEL_LO];
    end
  end

  // Sequencer: hold while start high, run after its fall
  assign finish = (state_r == ST_RUN) && tk.tick &&
                  (period_r == `TOTAL_PERIODS - 5'h01);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      period_r <= 5'h00;
    end else if (start_nxt) begin
      state_r <= ST_HOLD;
      period_r <= 5'h00;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          period_r <= 5'h00;
        end
        ST_HOLD: begin
          state_r <= ST_RUN;
          period_r <= 5'h00;
        end
        ST_RUN: begin
          if (finish) begin
            state_r <= ST_IDLE;
          end else if (tk.tick) begin
            period_r <= period_r + 5'h01;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      busy_r <= 1'b0;
    end else if (start_nxt) begin
      busy_r <= 1'b0;
    end else if (state_r == ST_HOLD) begin
      busy_r <= 1'b1;
    end else if (finish) begin
      busy_r <= 1'b0;
    end
  end

  // Request flag: set wins over software clear
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irq_flag_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= finish;
      if (finish) begin
        irq_flag_r <= 1'b1;
      end else if (reg_write && reg_addr == `REG_STAT &&
                   reg_wdata[`STAT_IRQ]) begin
        irq_flag_r <= 1'b0;
      end
    end
  end

  assign conv_done_irq = done_r;

  result_store u_result (
    .clock(clock),
    .sys_rst(sys_rst),
    .capture(finish),
    .data_in(core_result),
    .align_sel(align_r),
    .high_byte(res_hi),
    .low_byte(res_lo)
  );

  // Core control decode
  assign conv_power_enable = power_r;
  assign core_reset = (state_r == ST_HOLD) || start_r;
  assign sample_phase = (state_r == ST_RUN) &&
                        (period_r < `SAMPLE_PERIODS);
  assign convert_phase = (state_r == ST_RUN) &&
                         (period_r >= `SAMPLE_PERIODS);
  assign external_channel_select = chan_r;
  assign opamp_enable = opa_r;
  assign bandgap_buffer_enable = bgb_r;
  assign opamp_input_bandgap = ref_sel_r[`REF_SEL_HI];

  always_comb begin
    input_kind_nxt = IN_EXTERNAL;
    input_scale_nxt = 2'h0;
    if (int_sel_r >= `INT_SUPPLY_MIN && int_sel_r <= `INT_SUPPLY_MAX) begin
      input_kind_nxt = IN_SUPPLY;
      input_scale_nxt = 2'(int_sel_r - `INT_SUPPLY_MIN);
    end else if (int_sel_r >= `INT_OPA_MIN) begin
      input_kind_nxt = IN_OPAMP;
      input_scale_nxt = 2'(int_sel_r - `INT_OPA_MIN);
    end
  end

  // Kind 0 supply, 1 external, 2 bandgap; bandgap takes priority
  always_comb begin
    logic [3:0] eff;
    eff = ref_effective(ref_sel_r);
    ref_kind_nxt = 2'h0;
    ref_multiple_nxt = 3'h1;
    if (eff >= `REF_BG_X2) begin
      ref_kind_nxt = 2'h2;
      ref_multiple_nxt = 3'(eff - 4'h8);
    end else if (eff >= `REF_EXT_X1) begin
      ref_kind_nxt = 2'h1;
      ref_multiple_nxt = eff[2:0];
    end
  end

  // Registered so the core sees settled selections
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      input_kind <= IN_EXTERNAL;
      input_scale_log2 <= 2'h0;
      ref_kind <= 2'h0;
      ref_multiple <= 3'h1;
    end else begin
      input_kind <= input_kind_nxt;
      input_scale_log2 <= input_scale_nxt;
      ref_kind <= ref_kind_nxt;
      ref_multiple <= ref_multiple_nxt;
    end
  end

  // Read data one cycle after the strobe
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      unique case (reg_addr)
        `REG_CTRL: reg_rdata <= {start_r, busy_r, power_r, align_r,
                                 2'h0, chan_r};
        `REG_SRC: reg_rdata <= {int_sel_r, 2'h0, div_sel_r};
        `REG_REF: reg_rdata <= {opa_r, bgb_r, 2'h0, ref_sel_r};
        `REG_RES_HI: reg_rdata <= res_hi;
        `REG_RES_LO: reg_rdata <= res_lo;
        `REG_STAT: reg_rdata <= {7'h00, irq_flag_r};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // adc_control_sequencer

// ### adc_control_sequencer_monitor.sv
module adc_control_sequencer_monitor (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  // Core controls
  input wire logic conv_power_enable,
  input wire logic core_reset,
  input wire logic sample_phase,
  input wire logic convert_phase,
  input wire logic [1:0] external_channel_select,
  input wire logic opamp_enable,
  input wire logic bandgap_buffer_enable,
  input wire logic opamp_input_bandgap,
  input wire logic conv_done_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence ctrl_wr;
    reg_write && reg_addr == 3'h0;
  endsequence
  sequence start_set;
    ctrl_wr ##0 reg_wdata[7];
  endsequence
  sequence start_clr;
    ctrl_wr ##0 !reg_wdata[7] && core_reset;
  endsequence
  sequence run_begin;
    !core_reset && sample_phase ##1 !core_reset && !convert_phase;
  endsequence
  a_start_reset: assert property (start_set |=> core_reset &&
    !sample_phase && !convert_phase) else $error("start did not reset");
  a_release_run: assert property (start_clr |=> run_begin)
    else $error("release did not start");
  a_sample_convert: assert property ($fell(sample_phase) && !core_reset
    |-> convert_phase) else $error("sampling not followed by convert");
  a_phase_excl: assert property (!(sample_phase && convert_phase))
    else $error("both phases high");
  a_done_pulse: assert property ($fell(convert_phase) && !core_reset
    |-> conv_done_irq) else $error("no done pulse");
  a_irq_single: assert property (conv_done_irq |=> !conv_done_irq)
    else $error("done pulse too long");
  a_irq_idle: assert property (conv_done_irq |-> !sample_phase &&
    !convert_phase) else $error("done pulse while busy");
  a_power_bit: assert property (ctrl_wr |=>
    conv_power_enable == $past(reg_wdata[5])) else $error("power bit");
  a_channel_bits: assert property (ctrl_wr |=>
    external_channel_select == $past(reg_wdata[1:0]))
    else $error("channel select");
  a_amp_enables: assert property (reg_write && reg_addr == 3'h2 |=>
    opamp_enable == $past(reg_wdata[7]) &&
    bandgap_buffer_enable == $past(reg_wdata[6]) &&
    opamp_input_bandgap == $past(reg_wdata[3])) else $error("amp enables");
endmodule // adc_control_sequencer_monitor

bind adc_control_sequencer adc_control_sequencer_monitor u_monitor (
  .clock, .sys_rst, .reg_addr, .reg_wdata, .reg_write, .conv_power_enable,
  .core_reset, .sample_phase, .convert_phase, .external_channel_select,
  .opamp_enable, .bandgap_buffer_enable, .opamp_input_bandgap,
  .conv_done_irq);

// ### core_model.sv
module core_model (
  // Clock and phase
  input wire logic clock,
  input wire logic convert_phase,
  // Value to report
  input wire logic [11:0] level,
  output logic [11:0] core_result
);
  timeunit 1ns;
  timeprecision 1ns;
  logic flip_r = 1'b0;
  always @(posedge clock) flip_r <= !flip_r;
  // Valid only while converting, else a changing pattern
  assign core_result = convert_phase ? level : ~level ^ {12{flip_r}};
endmodule // core_model

// ### adc_control_sequencer_bench.sv
module adc_control_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, sys_rst = 1, reg_write = 0, reg_read = 0;
  logic [2:0] reg_addr = 3'h0, ref_multiple;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, c0, d;
  logic [11:0] core_result, level = 12'h000, rd_val;
  logic conv_power_enable, core_reset, sample_phase, convert_phase;
  logic opamp_enable, bandgap_buffer_enable, opamp_input_bandgap;
  logic conv_done_irq;
  logic [1:0] external_channel_select, input_kind, input_scale_log2, ref_kind;
  int mismatches = 0, checked = 0, cnt;
  adc_control_sequencer u_adc_control_sequencer (.clock, .sys_rst,
    .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .conv_power_enable, .core_reset, .sample_phase, .convert_phase,
    .external_channel_select, .input_kind, .input_scale_log2, .ref_kind,
    .ref_multiple, .opamp_enable, .bandgap_buffer_enable,
    .opamp_input_bandgap, .core_result, .conv_done_irq);
  core_model u_core_model (.clock, .convert_phase, .level, .core_result);
  initial forever #50 clock = ~clock;
  task automatic chk(logic [11:0] seen, logic [11:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(logic [2:0] a, logic [7:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    @(posedge clock);
    #1;
  endtask
  task automatic rd(logic [2:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 rd_val = 12'(reg_rdata);
  endtask
  // Packed as kind then multiple
  function automatic logic [4:0] ref_exp(logic [3:0] c);
    if (c >= 4'h1 && c <= 4'h4) return {2'h1, c[2:0]};
    if (c >= 4'ha && c <= 4'hc) return {2'h2, 3'(c - 4'h8)};
    return 5'h01;
  endfunction
  function automatic logic [3:0] src_exp(logic [2:0] c);
    if (c >= 3'h1 && c <= 3'h3) return {2'h1, 2'(c - 3'h1)};
    if (c >= 3'h5) return {2'h2, 2'(c - 3'h5)};
    return 4'h0;
  endfunction
  task automatic print_verdict;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'h2588));
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rd(3'(i));
      chk(rd_val, 12'h000);
    end
    wr(3'h1, 8'hff);
    wr(3'h2, 8'hff);
    wr(3'h0, 8'hff);
    wr(3'h6, 8'hff);
    rd(3'h1);
    chk(rd_val, 12'h0e7);
    rd(3'h2);
    chk(rd_val, 12'h0cf);
    rd(3'h0);
    chk(rd_val, 12'h0b3);
    rd(3'h6);
    chk(rd_val, 12'h000);
    for (int c = 0; c < 16; c++) begin
      if (c == 9) continue;
      d = (8'($urandom) & 8'hc0) | 8'(c);
      if (ref_exp(4'(c)) != 5'h01) d[7] = 1'b1;
      wr(3'h2, d);
      chk({ref_kind, ref_multiple, opamp_input_bandgap, opamp_enable,
        bandgap_buffer_enable}, {ref_exp(4'(c)), d[3], d[7], d[6]});
    end
    wr(3'h2, 8'h80);
    for (int c = 0; c < 8; c++) begin
      wr(3'h1, 8'(c << 5));
      chk({input_kind, input_scale_log2}, src_exp(3'(c)));
    end
    for (int k = 0; k < 8; k++) begin
      level = 12'($urandom);
      c0 = 8'h20 | (8'($urandom) & 8'h13);
      wr(3'h1, 8'(k) | (8'($urandom) & 8'he0));
      wr(3'h0, c0 | 8'h80);
      chk({core_reset, sample_phase, convert_phase}, 12'h4);
      wr(3'h0, c0);
      cnt = 0;
      do begin
        rd(3'h0);
        cnt += 2;
        if (cnt == 2) chk(rd_val[6], 12'h1);
      end while (rd_val[6] === 1'b1 && cnt < 6000);
      chk(cnt >= (15 << k) && cnt <= (17 << k) + 6, 12'h1);
      rd(3'h5);
      chk(rd_val, 12'h001);
      wr(3'h5, 8'h01);
      rd(3'h5);
      chk(rd_val, 12'h000);
      rd(3'h3);
      chk(rd_val, c0[4] ? level[11:8] : level[11:4]);
      rd(3'h4);
      chk(rd_val, c0[4] ? level[7:0] : {level[3:0], 4'h0});
      chk(external_channel_select, c0[1:0]);
    end
    wr(3'h0, 8'h10);
    rd(3'h4);
    chk(rd_val, level[7:0]);
    wr(3'h1, 8'h03);
    wr(3'h0, 8'h20);
    repeat (20) @(posedge clock);
    wr(3'h0, 8'ha0);
    wr(3'h0, 8'h20);
    repeat (30) @(posedge clock);
    wr(3'h0, 8'ha0);
    rd(3'h0);
    chk(rd_val, 12'h0a0);
    repeat (2100) @(posedge clock);
    rd(3'h5);
    chk(rd_val, 12'h000);
    print_verdict();
  end
endmodule // adc_control_sequencer_bench
